// ---- hw/hia_autodetect.sv ----
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// RULE_01: Each power-on or hard reset clears the choice and redoes detection.
// RULE_02: Type comes from strap levels latched after reset ends, not registers.
// RULE_03: Compact scheme: bus-select 0 with enable 0 UART, 0/1 SPI, 1 I2C.
// RULE_04: Serial types remap shared data pins to transmit, mux control, request, SPI, I2C.
// RULE_05: Full scheme, latch pin high: dedicated-address parallel bus, strobe kind.
// RULE_06: Address 000111 or 000110 picks multiplexed parallel, separate or common.
// RULE_07: A5..A2 zero and strobes high: UART 00, SPI 01, A1 high gives I2C.
// RULE_08: Chip select stays chip select in every interface type.
// RULE_09: Board holds straps steady through reset until the sampling point.
module hia_autodetect
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic full_scheme_in,
    input wire logic latch_pin_in,
    input wire logic bus_select_strap_in,
    input wire logic addr_enable_strap_in,
    input wire logic [5:0] addr_pin_in,
    input wire logic read_strobe_n_in,
    input wire logic write_strobe_n_in,
    input wire logic chip_select_n_in,
    input wire logic [7:0] data_pin_in,
    input wire logic uart_tx_in,
    input wire logic uart_mux_ctrl_in,
    input wire logic uart_data_request_in,
    input wire logic spi_miso_in,
    input wire logic spi_miso_oe_in,
    output logic [7:0] if_type_out,
    output logic detect_done_out,
    output logic chip_select_out,
    output logic uart_rx_out,
    output logic spi_nss_n_out,
    output logic spi_mosi_out,
    output logic spi_sck_out,
    output logic i2c_sda_out,
    output logic i2c_scl_out,
    output logic i2c_addr_enable_out,
    output logic [6:0] i2c_slave_addr_out,
    output logic [7:0] data_pin_out,
    output logic [7:0] data_pin_oe_out
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [20:0] pins_raw;
    logic [20:0] pins;

    assign pins_raw = {full_scheme_in, latch_pin_in, bus_select_strap_in,
        addr_enable_strap_in, addr_pin_in, read_strobe_n_in,
        write_strobe_n_in, chip_select_n_in, data_pin_in};

    hia_sync #(.WIDTH(21)) u_sync
    (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(pins_raw),
        .sync_out(pins)
    );

    logic s_full;
    logic s_latch;
    logic s_bsel;
    logic s_aen;
    logic [5:0] s_addr;
    logic s_rd_n;
    logic s_wr_n;
    logic s_cs_n;
    logic [7:0] s_data;

    assign s_full = pins[20];
    assign s_latch = pins[19];
    assign s_bsel = pins[18];
    assign s_aen = pins[17];
    assign s_addr = pins[16:11];
    assign s_rd_n = pins[10];
    assign s_wr_n = pins[9];
    assign s_cs_n = pins[8];
    assign s_data = pins[7:0];

    logic [6:0] slave_addr;

    // Address bit 0 sits on D6 and bit 6 on D0
    for (genvar k = 0; k < 7; k++)
    begin : g_slave_addr
        assign slave_addr[k] = s_data[6 - k]; // RULE_04
    end

    // ==========================================================
    // Strap decode
    // ==========================================================
    hia_pkg::hia_if_t decoded;

    always_comb
    begin
        decoded = hia_pkg::HIA_IF_NONE;
        if (!s_full)
        begin
            if (s_bsel) // RULE_03
                decoded = hia_pkg::HIA_IF_I2C;
            else if (s_aen)
                decoded = hia_pkg::HIA_IF_SPI;
            else
                decoded = hia_pkg::HIA_IF_UART;
        end
        else if (s_latch) // RULE_05
        begin
            if (s_rd_n && s_wr_n && s_addr[5:2] ==
                hia_pkg::HIA_ADDR_HI_SERIAL)
                decoded = hia_pkg::HIA_IF_NONE;
            else
                decoded = hia_pkg::HIA_IF_PAR_SEP_DED;
        end
        else if (s_addr == hia_pkg::HIA_ADDR_MUX_SEP) // RULE_06
            decoded = hia_pkg::HIA_IF_PAR_SEP_MUX;
        else if (s_addr == hia_pkg::HIA_ADDR_MUX_COM) // RULE_06
            decoded = hia_pkg::HIA_IF_PAR_COM_MUX;
        else
            decoded = hia_pkg::HIA_IF_PAR_COM_DED;
        // Serial check overrides; its latch pin carries RX/NSS/SDA
        if (s_full && s_rd_n && s_wr_n &&
            s_addr[5:2] == hia_pkg::HIA_ADDR_HI_SERIAL) // RULE_07
        begin
            if (s_addr[1])
                decoded = hia_pkg::HIA_IF_I2C;
            else if (s_addr[1:0] == hia_pkg::HIA_ADDR_LO_SPI)
                decoded = hia_pkg::HIA_IF_SPI;
            else
                decoded = hia_pkg::HIA_IF_UART;
        end
    end

    // ==========================================================
    // Latch after reset release
    // ==========================================================
    hia_pkg::hia_state_t state;
    logic [1:0] settle;
    logic aen_i2c;
    logic scheme_full;

    // Wait lets the synchronisers fill with real pin levels
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in) // RULE_01
        begin
            state <= hia_pkg::HIA_ST_WAIT;
            settle <= 2'h0;
        end
        else
        begin
            case (state)
                hia_pkg::HIA_ST_WAIT:
                begin
                    settle <= settle + 2'h1;
                    if (settle == hia_pkg::HIA_SETTLE_CYCLES - 2'h1)
                        state <= hia_pkg::HIA_ST_SAMPLE;
                end
                hia_pkg::HIA_ST_SAMPLE:
                    state <= hia_pkg::HIA_ST_DONE;
                hia_pkg::HIA_ST_DONE:
                    state <= hia_pkg::HIA_ST_DONE;
                default:
                    state <= hia_pkg::HIA_ST_WAIT;
            endcase
        end
    end

    // Latched once; later pin changes cannot switch the type
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            if_type_out <= hia_pkg::HIA_IF_NONE;
            detect_done_out <= 1'b0;
            scheme_full <= 1'b0;
        end
        else if (state == hia_pkg::HIA_ST_SAMPLE) // RULE_02
        begin
            if_type_out <= decoded;
            detect_done_out <= 1'b1;
            scheme_full <= s_full;
        end
    end

    // ==========================================================
    // Pin routing
    // ==========================================================
    always_comb
    begin
        // Scheme strap is latched; a late strap change must not move it
        aen_i2c = scheme_full ? s_addr[0] : s_aen;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            chip_select_out <= 1'b0;
            uart_rx_out <= 1'b1;
            spi_nss_n_out <= 1'b1;
            spi_mosi_out <= 1'b0;
            spi_sck_out <= 1'b0;
            i2c_sda_out <= 1'b1;
            i2c_scl_out <= 1'b1;
            i2c_addr_enable_out <= 1'b0;
            i2c_slave_addr_out <= 7'h00;
            data_pin_out <= 8'h00;
            data_pin_oe_out <= 8'h00;
        end
        else
        begin
            chip_select_out <= detect_done_out && !s_cs_n; // RULE_08
            uart_rx_out <= 1'b1;
            spi_nss_n_out <= 1'b1;
            spi_mosi_out <= 1'b0;
            spi_sck_out <= 1'b0;
            i2c_sda_out <= 1'b1;
            i2c_scl_out <= 1'b1;
            i2c_addr_enable_out <= 1'b0;
            i2c_slave_addr_out <= 7'h00;
            data_pin_out <= 8'h00;
            data_pin_oe_out <= 8'h00;
            case (if_type_out) // RULE_04
                hia_pkg::HIA_IF_UART:
                begin
                    uart_rx_out <= s_latch;
                    data_pin_out <= {uart_tx_in, uart_mux_ctrl_in,
                        uart_data_request_in, 5'h00};
                    data_pin_oe_out <= 8'hE0;
                end
                hia_pkg::HIA_IF_SPI:
                begin
                    spi_nss_n_out <= s_latch;
                    spi_mosi_out <= s_data[6];
                    spi_sck_out <= s_data[5];
                    data_pin_out <= {spi_miso_in, 7'h00};
                    data_pin_oe_out <= {spi_miso_oe_in, 7'h00};
                end
                hia_pkg::HIA_IF_I2C:
                begin
                    i2c_sda_out <= s_latch;
                    i2c_scl_out <= s_data[7];
                    i2c_slave_addr_out <= slave_addr;
                    i2c_addr_enable_out <= aen_i2c;
                end
                default:
                begin
                    data_pin_oe_out <= 8'h00;
                end
            endcase
        end
    end

endmodule : hia_autodetect

`default_nettype wire

// ---- hw/hia_pkg.sv ----
package hia_pkg;

    // ==========================================================
    // Detected interface types
    // ==========================================================
    typedef enum logic [7:0]
    {
        HIA_IF_NONE = 8'h00,
        HIA_IF_UART = 8'h01,
        HIA_IF_SPI = 8'h02,
        HIA_IF_I2C = 8'h04,
        HIA_IF_PAR_SEP_DED = 8'h08,
        HIA_IF_PAR_SEP_MUX = 8'h10,
        HIA_IF_PAR_COM_DED = 8'h20,
        HIA_IF_PAR_COM_MUX = 8'h40
    } hia_if_t;

    // ==========================================================
    // Sampler states
    // ==========================================================
    typedef enum logic [2:0]
    {
        HIA_ST_WAIT = 3'h1,
        HIA_ST_SAMPLE = 3'h2,
        HIA_ST_DONE = 3'h4
    } hia_state_t;

    // ==========================================================
    // Strap codes on the address pins
    // ==========================================================
    localparam logic [5:0] HIA_ADDR_MUX_SEP = 6'h07;
    localparam logic [5:0] HIA_ADDR_MUX_COM = 6'h06;
    localparam logic [3:0] HIA_ADDR_HI_SERIAL = 4'h0;
    localparam logic [1:0] HIA_ADDR_LO_UART = 2'h0;
    localparam logic [1:0] HIA_ADDR_LO_SPI = 2'h1;

    // Cycles waited after release before the sample state
    localparam logic [1:0] HIA_SETTLE_CYCLES = 2'h2;

endpackage : hia_pkg

// ---- hw/hia_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

module hia_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            stage1 <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : hia_sync

`default_nettype wire

// ---- tb/hia_autodetect_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========
// Detector port checker
// ==========
module hia_autodetect_monitor
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic full_scheme_in,
    input wire logic latch_pin_in,
    input wire logic bus_select_strap_in,
    input wire logic addr_enable_strap_in,
    input wire logic [5:0] addr_pin_in,
    input wire logic read_strobe_n_in,
    input wire logic write_strobe_n_in,
    input wire logic chip_select_n_in,
    input wire logic [7:0] data_pin_in,
    input wire logic uart_tx_in,
    input wire logic spi_miso_oe_in,
    input wire logic [7:0] if_type_out,
    input wire logic detect_done_out,
    input wire logic chip_select_out,
    input wire logic uart_rx_out,
    input wire logic spi_sck_out,
    input wire logic [7:0] data_pin_out,
    input wire logic [7:0] data_pin_oe_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    wire logic ser = addr_pin_in[5:2] == 4'h0 && read_strobe_n_in
        && write_strobe_n_in;

    a_done_four: assert property (
        $rose(rst_n_in) |-> !detect_done_out [*3] ##1 detect_done_out)
        else $error("detect done not on expected edge");
    a_type_holds: assert property (
        detect_done_out |=> detect_done_out && $stable(if_type_out))
        else $error("type changed without reset");
    a_idle_before: assert property (
        !detect_done_out |-> if_type_out == 8'h00
        && data_pin_oe_out == 8'h00 && !chip_select_out)
        else $error("outputs active before detection");
    a_compact_pick: assert property (
        $rose(detect_done_out) && !full_scheme_in |-> if_type_out ==
        (bus_select_strap_in ? 8'h04 : addr_enable_strap_in ? 8'h02 : 8'h01))
        else $error("wrong compact type");
    a_full_serial: assert property (
        $rose(detect_done_out) && full_scheme_in && ser |-> if_type_out ==
        (addr_pin_in[1] ? 8'h04 : addr_pin_in[0] ? 8'h02 : 8'h01))
        else $error("wrong full serial type");
    a_par_dedicated: assert property (
        $rose(detect_done_out) && full_scheme_in && !ser && latch_pin_in
        |-> if_type_out == 8'h08)
        else $error("wrong dedicated parallel type");
    a_par_mux: assert property (
        $rose(detect_done_out) && full_scheme_in && !ser && !latch_pin_in
        |-> if_type_out == (addr_pin_in == 6'h07 ? 8'h10
        : addr_pin_in == 6'h06 ? 8'h40 : 8'h20))
        else $error("wrong latch low parallel type");
    a_cs_follow: assert property (
        detect_done_out && $past(detect_done_out, 3)
        |-> chip_select_out == !$past(chip_select_n_in, 3))
        else $error("chip select not followed");
    a_uart_route: assert property (
        if_type_out == 8'h01 && $past(if_type_out, 3) == 8'h01
        |-> data_pin_oe_out == 8'hE0 && uart_rx_out == $past(latch_pin_in, 3)
        && data_pin_out[7] == $past(uart_tx_in, 1))
        else $error("uart pins misrouted");
    a_spi_route: assert property (
        if_type_out == 8'h02 && $past(if_type_out, 3) == 8'h02
        |-> spi_sck_out == $past(data_pin_in[5], 3)
        && data_pin_oe_out == {$past(spi_miso_oe_in, 1), 7'h00})
        else $error("spi pins misrouted");

    c_i2c: cover property ($rose(detect_done_out) && if_type_out == 8'h04);
    c_sep_mux: cover property ($rose(detect_done_out) && if_type_out == 8'h10);
    c_com_mux: cover property ($rose(detect_done_out) && if_type_out == 8'h40);
endmodule : hia_autodetect_monitor

bind hia_autodetect hia_autodetect_monitor u_monitor (.core_clk_in,
    .rst_n_in, .full_scheme_in, .latch_pin_in, .bus_select_strap_in,
    .addr_enable_strap_in, .addr_pin_in, .read_strobe_n_in,
    .write_strobe_n_in, .chip_select_n_in, .data_pin_in, .uart_tx_in,
    .spi_miso_oe_in, .if_type_out, .detect_done_out, .chip_select_out,
    .uart_rx_out, .spi_sck_out, .data_pin_out, .data_pin_oe_out);
`default_nettype wire

// ---- tb/hia_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========
// Board straps and host lines
// ==========
module hia_host_model
(
    input wire logic [3:0] cfg_in,
    input wire logic hold_in,
    input wire logic line_in,
    output logic full_scheme_out,
    output logic latch_pin_out,
    output logic bus_select_strap_out,
    output logic addr_enable_strap_out,
    output logic [5:0] addr_pin_out,
    output logic read_strobe_n_out,
    output logic write_strobe_n_out
);
    logic [11:0] s;

    always_comb
    begin
        case (cfg_in)
            4'h0: s = 12'h403;
            4'h1: s = 12'h503;
            4'h2: s = 12'h703;
            4'h3: s = 12'hC03;
            4'h4: s = 12'hC07;
            4'h5: s = 12'hC0F;
            4'h6: s = 12'hCAB;
            4'h7: s = 12'h81F;
            4'h8: s = 12'h81B;
            4'h9: s = 12'h857;
            4'hA: s = 12'hC01;
            default: s = 12'h802;
        endcase
    end

    // After the latch, spare straps flip so a late re-sample shows up
    assign full_scheme_out = hold_in ? s[11] : ~s[11];
    assign latch_pin_out = hold_in ? s[10] : line_in;
    assign bus_select_strap_out = hold_in ? s[9] : ~s[9];
    assign addr_enable_strap_out = s[8];
    assign addr_pin_out = hold_in ? s[7:2] : {~s[7:3], s[2]};
    assign read_strobe_n_out = hold_in ? s[1] : ~s[1];
    assign write_strobe_n_out = hold_in ? s[0] : ~s[0];
endmodule : hia_host_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========
// Detector bench
// ==========
module tb;
    logic core_clk_in, rst_n_in, full_scheme_in, latch_pin_in, hold, line;
    logic bus_select_strap_in, addr_enable_strap_in, read_strobe_n_in;
    logic write_strobe_n_in, chip_select_n_in, uart_tx_in, uart_mux_ctrl_in;
    logic uart_data_request_in, spi_miso_in, spi_miso_oe_in, detect_done_out;
    logic chip_select_out, uart_rx_out, spi_nss_n_out, spi_mosi_out;
    logic spi_sck_out, i2c_sda_out, i2c_scl_out, i2c_addr_enable_out;
    logic [3:0] cfg;
    logic [5:0] addr_pin_in;
    logic [6:0] i2c_slave_addr_out;
    logic [7:0] data_pin_in, if_type_out, data_pin_out, data_pin_oe_out;
    int errors, samples_checked, seed;
    int exp_type[$] = {1, 2, 4, 1, 2, 4, 8, 16, 64, 32, 8, 32};

    hia_autodetect DUT (.core_clk_in, .rst_n_in, .full_scheme_in,
        .latch_pin_in, .bus_select_strap_in, .addr_enable_strap_in,
        .addr_pin_in, .read_strobe_n_in, .write_strobe_n_in,
        .chip_select_n_in, .data_pin_in, .uart_tx_in, .uart_mux_ctrl_in,
        .uart_data_request_in, .spi_miso_in, .spi_miso_oe_in, .if_type_out,
        .detect_done_out, .chip_select_out, .uart_rx_out, .spi_nss_n_out,
        .spi_mosi_out, .spi_sck_out, .i2c_sda_out, .i2c_scl_out,
        .i2c_addr_enable_out, .i2c_slave_addr_out, .data_pin_out,
        .data_pin_oe_out);

    hia_host_model host (.cfg_in(cfg), .hold_in(hold), .line_in(line),
        .full_scheme_out(full_scheme_in), .latch_pin_out(latch_pin_in),
        .bus_select_strap_out(bus_select_strap_in),
        .addr_enable_strap_out(addr_enable_strap_in),
        .addr_pin_out(addr_pin_in), .read_strobe_n_out(read_strobe_n_in),
        .write_strobe_n_out(write_strobe_n_in));

    task automatic chk(input string what, input logic [7:0] e,
        input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic close_out;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    task automatic wait_done;
        for (int n = 0; n < 20; n++)
        begin
            @(posedge core_clk_in);
            #1;
            if (detect_done_out === 1'b1)
                return;
        end
        errors++;
        $display("BAD detect_done expected 1 seen %b", detect_done_out);
        close_out();
    endtask : wait_done

    task automatic check_routes(input int t);
        logic [7:0] oe, dv, sl;
        oe = t == 1 ? 8'hE0 : t == 2 ? {spi_miso_oe_in, 7'h00} : 8'h00;
        dv = t == 1 ? {uart_tx_in, uart_mux_ctrl_in, uart_data_request_in,
            5'h00} : {spi_miso_in, 7'h00};
        // Slave address bit 0 sits on D6, so the order is reversed
        for (int k = 0; k < 8; k++)
            sl[k] = t == 4 && k < 7 ? data_pin_in[6 - k] : 1'b0;
        chk("type", t[7:0], if_type_out);
        chk("oe", oe, data_pin_oe_out);
        chk("data", dv & oe, data_pin_out & oe);
        chk("slave", sl, {1'b0, i2c_slave_addr_out});
        chk("pins", {t == 1 ? line : 1'b1, t == 2 ? line : 1'b1,
            t == 2 ? data_pin_in[6:5] : 2'h0, t == 4 ? line : 1'b1,
            t == 4 ? data_pin_in[7] : 1'b1, t == 4, !chip_select_n_in},
            {uart_rx_out, spi_nss_n_out, spi_mosi_out, spi_sck_out,
            i2c_sda_out, i2c_scl_out, i2c_addr_enable_out, chip_select_out});
    endtask : check_routes

    initial
    begin
        core_clk_in = 1'b0;
        forever
            #50 core_clk_in = ~core_clk_in;
    end

    initial
    begin
        rst_n_in = 1'b0;
        {hold, line, cfg, chip_select_n_in, data_pin_in} = 15'h61FF;
        {uart_tx_in, uart_mux_ctrl_in, uart_data_request_in} = 3'h0;
        {spi_miso_in, spi_miso_oe_in, errors, samples_checked} = '0;
        seed = $urandom(32'hD479);
        for (int c = 0; c < 12; c++)
        begin
            rst_n_in <= 1'b0;
            hold <= 1'b1;
            cfg <= 4'(c);
            repeat (12) @(posedge core_clk_in);
            rst_n_in <= 1'b1;
            wait_done();
            repeat (4)
            begin
                @(posedge core_clk_in);
                hold <= 1'b0;
                {data_pin_in, line, chip_select_n_in, uart_tx_in,
                    uart_mux_ctrl_in, uart_data_request_in, spi_miso_in,
                    spi_miso_oe_in} <= 15'($urandom);
                repeat (4) @(posedge core_clk_in);
                #1;
                check_routes(exp_type[c]);
            end
            @(posedge core_clk_in);
        end
        close_out();
    end
endmodule : tb
`default_nettype wire
